// *** core/ccs_clock_ctrl.sv ***
// Clock speed select with idle and power-down gating
module ccs_clock_ctrl (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       double_speed_select,
  input  wire logic       idle_req,
  input  wire logic       power_down_req,
  output logic            core_tick,
  output logic            periph_tick,
  output logic            ram_hold,
  output logic            speed_active,
  output logic            cycle_end,
  output logic [2:0]      phase
);
  logic half;
  logic speed;
  logic next_half;
  logic next_speed;
  logic base_tick;
  logic half_rise;
  logic pgen_end;

  // ----------------------------------------
  // Divide by two and mode switch
  // ----------------------------------------
  // Speed changes only at a halved rising edge so no short tick appears
  always_comb begin
    next_half  = ~half;
    next_speed = speed;
    if (power_down_req) begin
      next_half = half;
    end else if (half_rise) begin
      next_speed = double_speed_select;
    end
  end

  assign half_rise = !power_down_req && !half;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      half  <= ccs_pkg::HALF_RESET;
      speed <= ccs_pkg::SPEED_RESET;
    end else begin
      half  <= next_half;
      speed <= next_speed;
    end
  end

  // ----------------------------------------
  // Tick selection and gating
  // ----------------------------------------
  // Standard mode ticks on halved edge; double speed ticks every clock
  assign base_tick   = !power_down_req && (speed ? 1'b1 : half_rise);
  assign periph_tick = base_tick;
  assign core_tick   = base_tick && !idle_req;
  assign ram_hold    = power_down_req;
  assign speed_active = speed;

  ccs_phase_gen u_pgen (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .tick      (core_tick),
    .phase     (phase),
    .cycle_end (pgen_end)
  );
  assign cycle_end = pgen_end;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Clocks since the last cycle end while running free in standard mode
  logic [4:0] gap;
  always_ff @(posedge mclk) begin
    if (!reset_n || cycle_end || speed || idle_req || power_down_req) begin
      gap <= 5'h0;
    end else begin
      gap <= gap + 5'h1;
    end
  end

  chk_reset_standard: assert property (@(posedge mclk) $rose(reset_n) |-> !speed)
    else $error("speed not standard after reset");
  chk_switch_on_half: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(speed) |-> $past(half_rise))
    else $error("speed changed off halved edge");
  chk_std_alternate: assert property (@(posedge mclk) disable iff (!reset_n)
    (!speed && !power_down_req && base_tick) ##1 !speed |-> !base_tick)
    else $error("standard tick not halved");
  chk_std_period: assert property (@(posedge mclk) disable iff (!reset_n)
    gap < 5'h0c)
    else $error("standard cycle longer than twelve clocks");
  chk_select_taken: assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(reset_n) && $past(half_rise)) |-> (speed == $past(double_speed_select)))
    else $error("select not taken on halved edge");
  chk_double_every: assert property (@(posedge mclk) disable iff (!reset_n)
    (speed && !power_down_req) |-> base_tick)
    else $error("double speed tick missing");
  chk_idle_core_stop: assert property (@(posedge mclk) disable iff (!reset_n)
    idle_req |-> !core_tick && (periph_tick == base_tick))
    else $error("idle gating wrong");
  chk_pd_all_stop: assert property (@(posedge mclk) disable iff (!reset_n)
    power_down_req |=> $stable(phase) && $stable(speed))
    else $error("state moved in power down");
  chk_six_ticks: assert property (@(posedge mclk) disable iff (!reset_n)
    (speed && !idle_req && !power_down_req && cycle_end) ##1
    (speed && !idle_req && !power_down_req)[*6] |-> cycle_end)
    else $error("double cycle not six clocks");
  chk_periph_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    periph_tick |-> !power_down_req)
    else $error("peripheral ticked in power down");
  chk_phase_range: assert property (@(posedge mclk) disable iff (!reset_n)
    phase <= ccs_pkg::PHASE_LAST)
    else $error("phase out of range");

  cov_double: cover property (@(posedge mclk) disable iff (!reset_n) $rose(speed));
  cov_back_std: cover property (@(posedge mclk) disable iff (!reset_n) $fell(speed));
  cov_idle: cover property (@(posedge mclk) disable iff (!reset_n) idle_req && periph_tick);
  cov_pd: cover property (@(posedge mclk) disable iff (!reset_n) power_down_req[*3]);
  cov_double_end: cover property (@(posedge mclk) disable iff (!reset_n) speed && cycle_end);
endmodule // ccs_clock_ctrl

// *** core/ccs_pkg.sv ***
// Constants for the core clock speed select block
// Operation
// - Double speed: six input periods per cycle
// - Standard mode halves input before phase generator
// - Halved clock feeds core and peripherals
// - Software bit disables the halving stage
// - Double speed bypasses divider for all
// - Mode change taken on halved rising edge
// - Idle stops core, peripherals keep running
// - Power-down keeps RAM, stops everything else
// - Static logic keeps state at any rate
package ccs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          PHASES_PER_CYCLE = 6;
  localparam int          STD_DIVIDE       = 2;
  localparam logic [2:0]  PHASE_LAST       = 3'(PHASES_PER_CYCLE - 1);
  localparam logic        SPEED_RESET      = 1'b0;
  localparam logic        HALF_RESET       = 1'b0;
  localparam logic [2:0]  PHASE_RESET      = 3'h0;
  localparam logic [1:0]  MCLK_PER_PHASE_STD = 2'(STD_DIVIDE);
endpackage

// *** core/ccs_phase_gen.sv ***
// Phase generator: counts six clock ticks per machine cycle
module ccs_phase_gen (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  output logic [2:0]      phase,
  output logic            cycle_end
);
  logic [2:0] next_phase;

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Holds value when tick is low, so a stopped or slow clock loses nothing
  always_comb begin
    next_phase = phase;
    if (tick) begin
      if (phase == ccs_pkg::PHASE_LAST) begin
        next_phase = ccs_pkg::PHASE_RESET;
      end else begin
        next_phase = phase + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase <= ccs_pkg::PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  assign cycle_end = tick && (phase == ccs_pkg::PHASE_LAST);
endmodule // ccs_phase_gen

// *** testbench/ccs_xtal_model.sv ***
// Crystal source model feeding the clock speed select block
module ccs_xtal_model (
  output logic mclk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free-running source; any duty is fine in standard mode
  initial mclk = 1'b0;
  always #(ccs_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
endmodule // ccs_xtal_model

// *** testbench/core_clock_speed_select_test.sv ***
// Self-checking bench for the clock speed select block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module core_clock_speed_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk;
  logic       reset_n = 1'b0;
  logic       dss     = 1'b0;
  logic       idle    = 1'b0;
  logic       pd      = 1'b0;
  logic       core_tick, periph_tick, ram_hold, speed_active, cycle_end;
  logic [2:0] phase, held;
  int         bad_count = 0, checks = 0, nc, np, ne;
  ccs_xtal_model ccs_xtal_model_i (.mclk(mclk));
  ccs_clock_ctrl ccs_clock_ctrl_i (.mclk(mclk), .reset_n(reset_n),
    .double_speed_select(dss), .idle_req(idle), .power_down_req(pd),
    .core_tick(core_tick), .periph_tick(periph_tick), .ram_hold(ram_hold),
    .speed_active(speed_active), .cycle_end(cycle_end), .phase(phase));
  task automatic drive(input logic d, input logic i, input logic p);
    @(posedge mclk);
    dss <= d;
    idle <= i;
    pd <= p;
    // Mode change may wait for the next halved edge
    repeat (3) @(posedge mclk);
    // Look at registered outputs away from the edge that launches them
    @(negedge mclk);
  endtask
  task automatic count(input int n);
    nc = 0; np = 0; ne = 0;
    repeat (n) begin
      @(negedge mclk);
      nc += core_tick; np += periph_tick; ne += cycle_end;
    end
  endtask
  task automatic t_reset();
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    `CHK(speed_active, 1'b0)
    `CHK(phase, 3'h0)
  endtask
  task automatic t_std();
    count(12);
    `CHK(nc, 6)
    `CHK(np, 6)
    `CHK(ne, 1)
  endtask
  task automatic t_double();
    drive(1'b1, 1'b0, 1'b0);
    `CHK(speed_active, 1'b1)
    count(6);
    `CHK(nc, 6)
    `CHK(np, 6)
    `CHK(ne, 1)
    drive(1'b0, 1'b0, 1'b0);
    `CHK(speed_active, 1'b0)
    t_std();
  endtask
  task automatic t_idle();
    drive(1'b0, 1'b1, 1'b0);
    count(12);
    `CHK(nc, 0)
    `CHK(np, 6)
  endtask
  task automatic t_pd();
    drive(1'b1, 1'b0, 1'b1);
    held = phase;
    count(12);
    `CHK(ram_hold, 1'b1)
    `CHK(nc + np, 0)
    `CHK(phase, held)
    `CHK(speed_active, 1'b0)
    drive(1'b0, 1'b0, 1'b0);
    t_std();
  endtask
  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(ccs_pkg::CLK_PERIOD_NS * 2000);
    bad_count++;
    test_done();
  end
  initial begin
    t_reset();
    t_std();
    t_double();
    t_idle();
    t_pd();
    drive(1'b1, 1'b0, 1'b0);
    reset_n <= 1'b0;
    t_reset();
    test_done();
  end
endmodule // core_clock_speed_select_test
